//--- pdc_divider_config.sv
// apb register file and staged configuration for the prescalers and feedback divider
`timescale 1ns/10ps
// ==========================================================
// Function
// - the first prescaler ratio in bits [4:3] selects 2, 2.5, 3 or 3.5, reset code 10b.
// - the second prescaler ratio in bits [4:3] uses the same encoding, reset code 10b.
// - the third prescaler ratio in bits [3:2] uses the same encoding, reset code 00b.
// - bit 2 of the first prescaler register turns its regulator on, reset 1.
// - bit 2 of the second prescaler register turns its regulator on, reset 1.
// - writing 1 to bit 0 of the first register clears that divider at once and self-clears.
// - writing 1 to bit 0 of the second register clears that divider at once and self-clears.
// - writing 1 to bit 0 of the third register clears that divider at once and self-clears.
// - the feedback value 0x01 to 0xFF is the feedback divide ratio itself.
// - a feedback value of 0x00 disables the feedback divider.
// - the feedback value resets to 0x0A and is read/write.
module pdc_divider_config (
	// apb slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [13:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// first prescaler, feeds channel dividers one and two
	output logic [1:0] first_prescaler_ratio,
	output logic first_prescaler_on,
	output logic first_prescaler_regulator_on,
	output logic first_prescaler_clear,
	// second prescaler, feeds channel dividers three and four
	output logic [1:0] second_prescaler_ratio,
	output logic second_prescaler_on,
	output logic second_prescaler_regulator_on,
	output logic second_prescaler_clear,
	// third prescaler
	output logic [1:0] third_prescaler_ratio,
	output logic third_prescaler_on,
	output logic third_prescaler_clear,
	// feedback divider
	output logic [7:0] feedback_ratio,
	output logic feedback_on,
	// prescaler cycle markers
	output logic [2:0] prescaler_wrap
);
	// ==========================================================
	// bus decode
	logic access;
	logic wr;
	logic hit_first;
	logic hit_second;
	logic hit_third;
	logic hit_feedback;
	logic hit_strobe;
	logic mapped;
	assign access = psel && penable;
	assign wr = access && pwrite;
	assign hit_first = (paddr == pdc_pkg::FIRST_PRESCALER_CTRL_ADDR);
	assign hit_second = (paddr == pdc_pkg::SECOND_PRESCALER_CTRL_ADDR);
	assign hit_third = (paddr == pdc_pkg::THIRD_PRESCALER_CTRL_ADDR);
	assign hit_feedback = (paddr == pdc_pkg::FEEDBACK_DIVIDE_VALUE_ADDR);
	assign hit_strobe = (paddr == pdc_pkg::TRANSFER_STROBE_ADDR);
	assign mapped = hit_first || hit_second || hit_third || hit_feedback
		|| hit_strobe;
	// zero-wait slave; unmapped addresses answer with an error
	assign pready = 1'b1;
	assign pslverr = access && !mapped;
	// reserved bits are not stored, so a careless write cannot leak into them
	logic [7:0] wbyte;
	assign wbyte = pwdata[7:0];
	logic strobe;
	assign strobe = wr && hit_strobe && wbyte[pdc_pkg::TRANSFER_BIT];
	// ==========================================================
	// shadow (staged) registers, read back by software
	logic [4:1] first_shadow_reg;
	logic [4:1] second_shadow_reg;
	logic [3:1] third_shadow_reg;
	logic [7:0] feedback_shadow_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			first_shadow_reg <= pdc_pkg::FIRST_PRESCALER_RESET[4:1];
			second_shadow_reg <= pdc_pkg::SECOND_PRESCALER_RESET[4:1];
			third_shadow_reg <= pdc_pkg::THIRD_PRESCALER_RESET[3:1];
			feedback_shadow_reg <= pdc_pkg::FEEDBACK_DIVIDE_RESET;
		end else begin
			if (wr && hit_first) begin
				first_shadow_reg <= wbyte[4:1];
			end
			if (wr && hit_second) begin
				second_shadow_reg <= wbyte[4:1];
			end
			if (wr && hit_third) begin
				third_shadow_reg <= wbyte[3:1];
			end
			if (wr && hit_feedback) begin
				feedback_shadow_reg <= wbyte;
			end
		end
	end
	// ==========================================================
	// active registers, loaded by the transfer strobe
	logic [4:1] first_active_reg;
	logic [4:1] second_active_reg;
	logic [3:1] third_active_reg;
	logic [7:0] feedback_active_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			first_active_reg <= pdc_pkg::FIRST_PRESCALER_RESET[4:1];
			second_active_reg <= pdc_pkg::SECOND_PRESCALER_RESET[4:1];
			third_active_reg <= pdc_pkg::THIRD_PRESCALER_RESET[3:1];
			feedback_active_reg <= pdc_pkg::FEEDBACK_DIVIDE_RESET;
		end else if (strobe) begin
			first_active_reg <= first_shadow_reg;
			second_active_reg <= second_shadow_reg;
			third_active_reg <= third_shadow_reg;
			feedback_active_reg <= feedback_shadow_reg;
		end
	end
	// ==========================================================
	// live clear pulses: one cycle, bypass the strobe, never stored
	logic [2:0] clear_reg;
	logic [2:0] clear_next;
	assign clear_next[0] = wr && hit_first && wbyte[pdc_pkg::CLEAR_BIT];
	assign clear_next[1] = wr && hit_second && wbyte[pdc_pkg::CLEAR_BIT];
	assign clear_next[2] = wr && hit_third && wbyte[pdc_pkg::CLEAR_BIT];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clear_reg <= 3'h0;
		end else begin
			clear_reg <= clear_next;
		end
	end
	assign first_prescaler_clear = clear_reg[0];
	assign second_prescaler_clear = clear_reg[1];
	assign third_prescaler_clear = clear_reg[2];
	// ==========================================================
	// outputs from active registers
	assign first_prescaler_ratio = first_active_reg[4:3];
	assign first_prescaler_regulator_on = first_active_reg[2];
	assign first_prescaler_on = first_active_reg[1];
	assign second_prescaler_ratio = second_active_reg[4:3];
	assign second_prescaler_regulator_on = second_active_reg[2];
	assign second_prescaler_on = second_active_reg[1];
	assign third_prescaler_ratio = third_active_reg[3:2];
	assign third_prescaler_on = third_active_reg[1];
	assign feedback_ratio = feedback_active_reg;
	assign feedback_on = (feedback_active_reg != pdc_pkg::FEEDBACK_OFF);
	// ==========================================================
	// divider models: each counts its ratio in half steps
	logic [5:0] ratios;
	logic [2:0] enables;
	assign ratios = {third_prescaler_ratio, second_prescaler_ratio,
		first_prescaler_ratio};
	assign enables = {third_prescaler_on, second_prescaler_on,
		first_prescaler_on};
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_pre
			pdc_prescaler u_pre (
				.pclk(pclk),
				.presetn(presetn),
				.ratio(ratios[2*g+1:2*g]),
				.enable(enables[g]),
				.clear(clear_reg[g]),
				.phase_count(),
				.half_phase(),
				.wrap(prescaler_wrap[g])
			);
		end
	endgenerate
	// ==========================================================
	// read mux: clear bits read as zero, reserved bits as zero
	logic [7:0] rbyte;
	assign rbyte = hit_first ? {3'h0, first_shadow_reg, 1'b0} :
		hit_second ? {3'h0, second_shadow_reg, 1'b0} :
		hit_third ? {4'h0, third_shadow_reg, 1'b0} :
		hit_feedback ? feedback_shadow_reg : 8'h00;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (psel && !penable && !pwrite) begin
			prdata <= {24'h0, rbyte};
		end
	end
endmodule : pdc_divider_config

//--- pdc_pkg.sv
// package of register map, field layout and reset values for the divider configuration block
package pdc_pkg;
	// ==========================================================
	// register indices (printed offsets) and byte addresses
	localparam logic [11:0] FIRST_PRESCALER_CTRL_IDX = 12'h020;
	localparam logic [11:0] SECOND_PRESCALER_CTRL_IDX = 12'h021;
	localparam logic [11:0] THIRD_PRESCALER_CTRL_IDX = 12'h022;
	localparam logic [11:0] FEEDBACK_DIVIDE_VALUE_IDX = 12'h023;
	localparam logic [11:0] TRANSFER_STROBE_IDX = 12'h030;
	localparam logic [13:0] FIRST_PRESCALER_CTRL_ADDR = {FIRST_PRESCALER_CTRL_IDX, 2'b00};
	localparam logic [13:0] SECOND_PRESCALER_CTRL_ADDR = {SECOND_PRESCALER_CTRL_IDX, 2'b00};
	localparam logic [13:0] THIRD_PRESCALER_CTRL_ADDR = {THIRD_PRESCALER_CTRL_IDX, 2'b00};
	localparam logic [13:0] FEEDBACK_DIVIDE_VALUE_ADDR = {FEEDBACK_DIVIDE_VALUE_IDX, 2'b00};
	localparam logic [13:0] TRANSFER_STROBE_ADDR = {TRANSFER_STROBE_IDX, 2'b00};
	// ==========================================================
	// field positions
	localparam int CLEAR_BIT = 0;
	localparam int ENABLE_BIT = 1;
	localparam int REGULATOR_BIT = 2;
	localparam int WIDE_RATIO_LSB = 3;
	localparam int NARROW_RATIO_LSB = 2;
	localparam int TRANSFER_BIT = 0;
	// ==========================================================
	// reset values of the live (stored) registers
	localparam logic [7:0] FIRST_PRESCALER_RESET = 8'h16;
	localparam logic [7:0] SECOND_PRESCALER_RESET = 8'h16;
	localparam logic [7:0] THIRD_PRESCALER_RESET = 8'h02;
	localparam logic [7:0] FEEDBACK_DIVIDE_RESET = 8'h0A;
	// ratio code: divide by 2, 2.5, 3, 3.5
	localparam logic [1:0] RATIO_DIV2 = 2'h0;
	localparam logic [1:0] RATIO_DIV2P5 = 2'h1;
	localparam logic [1:0] RATIO_DIV3 = 2'h2;
	localparam logic [1:0] RATIO_DIV3P5 = 2'h3;
	// feedback value that turns the divider off
	localparam logic [7:0] FEEDBACK_OFF = 8'h00;
endpackage : pdc_pkg

//--- pdc_prescaler.sv
// one prescaler: ratio/enable inputs, half-step divider with wrap output and live clear
`timescale 1ns/10ps
module pdc_prescaler (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// configuration
	input wire logic [1:0] ratio,
	input wire logic enable,
	input wire logic clear,
	// divider state
	output logic [2:0] phase_count,
	output logic half_phase,
	output logic wrap
);
	// ==========================================================
	// counts half-cycles: a ratio r in halves is 4..7 half steps
	logic [2:0] phase_reg;
	logic [2:0] phase_next;
	logic [2:0] last_phase;
	assign last_phase = {1'b0, ratio} + 3'h3;
	assign wrap = enable && (phase_reg == last_phase);
	assign phase_next = (!enable || wrap) ? 3'h0 : 3'(phase_reg + 3'h1);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_reg <= 3'h0;
		end else if (clear) begin
			phase_reg <= 3'h0;
		end else begin
			phase_reg <= phase_next;
		end
	end
	assign phase_count = phase_reg;
	assign half_phase = ratio[0];
endmodule : pdc_prescaler

//--- pdc_assertions.sv
// checker of port behaviour for the divider configuration block
`timescale 1ns/10ps
module pdc_checker (
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [13:0] paddr,
	input wire logic [31:0] pwdata,
	// prescalers
	input wire logic [1:0] first_prescaler_ratio,
	input wire logic first_prescaler_on,
	input wire logic first_prescaler_regulator_on,
	input wire logic first_prescaler_clear,
	input wire logic [1:0] second_prescaler_ratio,
	input wire logic second_prescaler_on,
	input wire logic second_prescaler_regulator_on,
	input wire logic second_prescaler_clear,
	input wire logic [1:0] third_prescaler_ratio,
	input wire logic third_prescaler_on,
	input wire logic third_prescaler_clear,
	// feedback
	input wire logic [7:0] feedback_ratio,
	input wire logic feedback_on
);
	// ==========================================================
	// helpers
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire wacc = psel && penable && pwrite && pwdata[0];
	wire strb = wacc && paddr == pdc_pkg::TRANSFER_STROBE_ADDR;
	wire [18:0] cfg = {first_prescaler_ratio, first_prescaler_on,
		first_prescaler_regulator_on, second_prescaler_ratio,
		second_prescaler_on, second_prescaler_regulator_on,
		third_prescaler_ratio, third_prescaler_on, feedback_ratio};
	// ==========================================================
	// assertions
	chk_first_clear: assert property (first_prescaler_clear ==
		$past(wacc && paddr == pdc_pkg::FIRST_PRESCALER_CTRL_ADDR))
		else $error("first clear pulse wrong");
	chk_second_clear: assert property (second_prescaler_clear ==
		$past(wacc && paddr == pdc_pkg::SECOND_PRESCALER_CTRL_ADDR))
		else $error("second clear pulse wrong");
	chk_third_clear: assert property (third_prescaler_clear ==
		$past(wacc && paddr == pdc_pkg::THIRD_PRESCALER_CTRL_ADDR))
		else $error("third clear pulse wrong");
	// config may only move on the edge after a strobe
	chk_staged_hold: assert property ($past(strb) || $stable(cfg))
		else $error("config moved without strobe");
	chk_feedback_off: assert property (feedback_on == (feedback_ratio != 8'h00))
		else $error("feedback enable wrong");
	chk_first_reset: assert property ($rose(presetn) |-> cfg[18:15] == 4'hB)
		else $error("first prescaler reset wrong");
	chk_second_reset: assert property ($rose(presetn) |-> cfg[14:11] == 4'hB)
		else $error("second prescaler reset wrong");
	chk_third_reset: assert property ($rose(presetn) |-> cfg[10:8] == 3'h1)
		else $error("third prescaler reset wrong");
	chk_fb_reset: assert property ($rose(presetn) |-> cfg[7:0] == 8'h0A)
		else $error("feedback reset wrong");
endmodule : pdc_checker
bind pdc_divider_config pdc_checker u_chk (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .first_prescaler_ratio, .first_prescaler_on,
	.first_prescaler_regulator_on, .first_prescaler_clear,
	.second_prescaler_ratio, .second_prescaler_on,
	.second_prescaler_regulator_on, .second_prescaler_clear,
	.third_prescaler_ratio, .third_prescaler_on, .third_prescaler_clear,
	.feedback_ratio, .feedback_on);

//--- testbench.sv
// self-checking bench of the divider configuration block
`timescale 1ns/10ps
module testbench;
	// ==========================================================
	// signals
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, pready, pslverr, er;
	logic [13:0] paddr = 14'h0000;
	logic [31:0] pwdata = 32'h00000000, prdata, rd, ea;
	logic [1:0] first_prescaler_ratio, second_prescaler_ratio;
	logic [1:0] third_prescaler_ratio, c;
	logic first_prescaler_on, first_prescaler_regulator_on;
	logic second_prescaler_on, second_prescaler_regulator_on;
	logic third_prescaler_on, feedback_on, first_prescaler_clear;
	logic second_prescaler_clear, third_prescaler_clear;
	logic [7:0] feedback_ratio, v;
	logic [2:0] prescaler_wrap;
	logic [13:0] ca [3] = '{pdc_pkg::FIRST_PRESCALER_CTRL_ADDR,
		pdc_pkg::SECOND_PRESCALER_CTRL_ADDR, pdc_pkg::THIRD_PRESCALER_CTRL_ADDR};
	int err_total = 0;
	int checks = 0;
	wire [31:0] cfg_a = {24'h000000, first_prescaler_ratio, first_prescaler_on,
		first_prescaler_regulator_on, second_prescaler_ratio,
		second_prescaler_on, second_prescaler_regulator_on};
	wire [31:0] cfg_b = {20'h00000, third_prescaler_ratio, third_prescaler_on,
		feedback_on, feedback_ratio};
	wire [31:0] clr = {29'h0, first_prescaler_clear, second_prescaler_clear,
		third_prescaler_clear};
	always #25 pclk = ~pclk;
	// the clear pulse is gone by the time a transfer task returns
	logic [31:0] clr_q = 32'h00000000;
	always @(posedge pclk) clr_q <= clr;
	pdc_divider_config DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .first_prescaler_ratio,
		.first_prescaler_on, .first_prescaler_regulator_on,
		.first_prescaler_clear, .second_prescaler_ratio, .second_prescaler_on,
		.second_prescaler_regulator_on, .second_prescaler_clear,
		.third_prescaler_ratio, .third_prescaler_on, .third_prescaler_clear,
		.feedback_ratio, .feedback_on, .prescaler_wrap);
	// ==========================================================
	// shared tasks
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp
	// one full apb transfer; an idle edge follows so no signal is set twice
	task apb(input logic w, input logic [13:0] a, input logic [7:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
		#1;
	endtask : apb
	task stop_test;
		if (err_total == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : stop_test
	// ==========================================================
	// scenarios
	task t_reset;
		int n0;
		int n2;
		n0 = 0;
		n2 = 0;
		// divide by 3 wraps every 6 half steps, divide by 2 every 4
		repeat (12) begin
			@(posedge pclk);
			#1;
			n0 += prescaler_wrap[0];
			n2 += prescaler_wrap[2];
		end
		cmp(n0, 32'h2);
		cmp(n2, 32'h3);
		for (int i = 0; i < 3; i++) begin
			apb(1'b0, ca[i], 8'h00);
			cmp(rd, i == 2 ? 32'h02 : 32'h16);
		end
		apb(1'b0, pdc_pkg::FEEDBACK_DIVIDE_VALUE_ADDR, 8'h00);
		cmp(rd, 32'h0A);
		cmp(cfg_a, 32'hBB);
		cmp(cfg_b, 32'h30A);
	endtask : t_reset
	task t_stage;
		ea = 32'hBB;
		for (int i = 0; i < 4; i++) begin
			c = i[1:0];
			v = {3'h0, c, c[0], ~&c, 1'b0};
			apb(1'b1, ca[0], v);
			apb(1'b1, ca[1], v);
			apb(1'b1, ca[2], {4'h0, c, ~&c, 1'b0});
			cmp(cfg_a, ea);
			apb(1'b0, ca[1], 8'h00);
			cmp(rd, {24'h0, v});
			apb(1'b1, pdc_pkg::TRANSFER_STROBE_ADDR, 8'h01);
			ea = {24'h0, c, ~&c, c[0], c, ~&c, c[0]};
			cmp(cfg_a, ea);
			cmp(cfg_b, {20'h0, c, ~&c, 1'b1, 8'h0A});
		end
	endtask : t_stage
	task t_clear;
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, ca[i], 8'h03);
			cmp(clr_q, 32'h4 >> i);
			@(posedge pclk);
			#1 cmp(clr, 32'h0);
			apb(1'b0, ca[i], 8'h00);
			cmp(rd, 32'h02);
		end
	endtask : t_clear
	task t_feedback;
		for (int i = 0; i < 3; i++) begin
			v = i == 0 ? 8'h00 : (i == 1 ? 8'h01 : 8'hFF);
			apb(1'b1, pdc_pkg::FEEDBACK_DIVIDE_VALUE_ADDR, v);
			apb(1'b1, pdc_pkg::TRANSFER_STROBE_ADDR, 8'h01);
			cmp(cfg_b[8:0], {v != 8'h00, v});
			apb(1'b0, pdc_pkg::FEEDBACK_DIVIDE_VALUE_ADDR, 8'h00);
			cmp(rd, {24'h0, v});
		end
	endtask : t_feedback
	task t_unmapped;
		apb(1'b1, 14'h0100, 8'hFF);
		cmp(er, 1'b1);
		apb(1'b0, 14'h0100, 8'h00);
		cmp(er, 1'b1);
		cmp(rd, 32'h0);
	endtask : t_unmapped
	// ==========================================================
	// main sequence and watchdog
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		#1;
		t_reset;
		t_stage;
		t_clear;
		t_feedback;
		t_unmapped;
		stop_test;
	end
	initial begin
		repeat (2000) @(posedge pclk);
		err_total++;
		stop_test;
	end
endmodule : testbench
